/* File: mgmt_phy_model.sv */
// Purpose: Behavioural PHY on the far side of the two-wire management bus.
// Assumes: The device changes the data line at bit start and raises the pin clock mid bit.
// Notes:   The data line has a pull-up, so a released line reads high.
`default_nettype none

// ****************************************
// Management PHY model
// ****************************************
module mgmt_phy_model (
   input wire logic mgmtSerialClock,
   input wire logic mdioOut,
   input wire logic mdioOe,
   input wire logic ackEn,
   input wire logic [15:0] rdVal,
   output logic mdioIn,
   output logic gotWrite,
   output logic [9:0] gotAddr,
   output logic [15:0] gotData,
   output int frames
);
   timeunit 1ns;
   timeprecision 1ps;
   logic phyOe = 1'b0; // High while the model drives the data line.
   logic phyOut = 1'b1; // Level the model drives.
   logic [12:0] hdr = 13'h0; // Start bit two, opcode, PHY and register address.
   int cnt = 0; // Bit number in the frame, 0 while hunting for a start bit.

   // The pull-up wins only when nobody drives, so a silent PHY reads as all ones.
   assign mdioIn = mdioOe ? mdioOut : (phyOe ? phyOut : 1'b1);

   initial begin
      gotWrite = 1'b0;
      gotAddr = 10'h0;
      gotData = 16'h0;
      frames = 0;
   end

   // Frames are decoded on the pin clock; the model answers right after each rising edge.
   always @(posedge mgmtSerialClock) begin
      if (cnt == 0) begin
         // A driven zero after idle or preamble ones is the first start bit.
         if (mdioOe && !mdioOut) cnt = 1;
      end else begin
         if (cnt <= 13) hdr = {hdr[11:0], mdioOut};
         if (cnt == 13) begin
            gotWrite = (hdr[11:10] == 2'h1);
            gotAddr = hdr[9:0];
         end
         // On reads the model drives the acknowledge bit low, then the data MSB first.
         if (!gotWrite && cnt >= 14 && cnt <= 30) begin
            phyOe = ackEn;
            phyOut = (cnt == 14) ? 1'b0 : rdVal[30 - cnt];
         end
         if (gotWrite && cnt >= 16) gotData = {gotData[14:0], mdioOut};
         if (cnt == 31) begin
            phyOe = 1'b0;
            phyOut = 1'b1;
            frames++;
            cnt = 0;
         end else begin
            cnt++;
         end
      end
   end
endmodule : mgmt_phy_model
`default_nettype wire

/* File: phy_mgmt_serial_engine.sv */
// Purpose: Shared constants and the serial frame engine that runs on the link clock.
// Assumes: Request fields hold still from a request toggle until the done toggle answers it.
// Notes:   One bit time is eight link clock cycles; the pin clock is divided from the link clock.
`default_nettype none

// ****************************************
// Shared constants
// ****************************************
package mgmt_frame_pkg;
   localparam int NUM_CH = 2;                          // Number of user access channels.
   localparam logic [1:0] START_CODE = 2'h1;           // Frame start pattern 01.
   localparam logic [1:0] OP_READ = 2'h2;              // Read opcode 10.
   localparam logic [1:0] OP_WRITE = 2'h1;             // Write opcode 01.
   localparam logic [1:0] TA_WRITE = 2'h2;             // Turnaround driven as 10 on writes.
   localparam logic [4:0] TA_POS = 5'h0e;              // Frame bit where turnaround begins.
   localparam logic [4:0] ACK_POS = 5'h0f;             // Second turnaround bit, the acknowledge.
   localparam logic [4:0] DATA_POS = 5'h10;            // First data bit of the frame.
   localparam logic [5:0] FRAME_FIRST = 6'h20;         // Bit index of the start code.
   localparam logic [5:0] PRE_FIRST = 6'h00;           // Bit index of the first preamble bit.
   localparam logic [5:0] LAST_BIT = 6'h3f;            // Bit index of the last data bit.
   localparam logic [2:0] TICK_RISE = 3'h4;            // Tick where the pin clock goes high.
   localparam logic [2:0] TICK_SAMPLE = 3'h3;          // Tick where read data is taken.
   localparam logic [2:0] TICK_LAST = 3'h7;            // Last tick of a bit time.
   localparam logic [1:0] MASK_RST = 2'h0;             // Completion mask after reset.
   localparam logic [31:0] ALIVE_RST = 32'h0;          // Presence flags after reset.
endpackage : mgmt_frame_pkg

// ****************************************
// Serial frame engine
// ****************************************
module phy_mgmt_serial_engine (
   input wire logic linkClk,
   input wire logic rst_n,
   input wire logic reqToggle,
   input wire logic reqWrite,
   input wire logic reqPreamble,
   input wire logic [4:0] reqPhy,
   input wire logic [4:0] reqReg,
   input wire logic [15:0] reqData,
   input wire logic mdioIn,
   output logic doneToggle,
   output logic [15:0] rspData,
   output logic rspAck,
   output logic mgmtSerialClock,
   output logic mdioOut,
   output logic mdioOe
);
   typedef enum logic {ST_IDLE = 1'b0, ST_RUN = 1'b1} eng_state_e;

   eng_state_e state_q;        // Idle or running a frame.
   logic reqSync1_q;           // First stage of the request toggle synchroniser.
   logic reqSync2_q;           // Second stage, safe to read.
   logic reqSeen_q;            // Last request toggle already served.
   logic inSync1_q;            // First stage of the data pin synchroniser.
   logic inSync2_q;            // Second stage, safe to read.
   logic [2:0] tick_q;         // Position inside one bit time.
   logic [5:0] bitIdx_q;       // Bit index; upper half is the frame proper.
   logic [31:0] frame_q;       // Outgoing frame, shifted out from the top.
   logic [15:0] rdShift_q;     // Incoming read data.
   logic isWrite_q;            // The running frame is a write.
   logic ackSeen_q;            // The device pulled the line low in the acknowledge bit.
   logic inFrame;
   logic bitEnd;
   logic startReq;
   logic [4:0] fIdx;

   assign inFrame = bitIdx_q[5];
   assign fIdx = bitIdx_q[4:0];
   assign bitEnd = (state_q == ST_RUN) && (tick_q == mgmt_frame_pkg::TICK_LAST);
   assign startReq = (state_q == ST_IDLE) && (reqSync2_q != reqSeen_q);

   // Two flip-flops on the request toggle and on the data pin; only stage two reads stage one.
   always_ff @(posedge linkClk or negedge rst_n) begin
      if (!rst_n) begin
         reqSync1_q <= 1'b0;
         reqSync2_q <= 1'b0;
         inSync1_q <= 1'b1;
         inSync2_q <= 1'b1;
      end else begin
         reqSync1_q <= reqToggle;
         reqSync2_q <= reqSync1_q;
         inSync1_q <= mdioIn;
         inSync2_q <= inSync1_q;
      end
   end

   // Frame sequencer. The frame is built once at start so the request fields are read only then.
   always_ff @(posedge linkClk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_IDLE;
         reqSeen_q <= 1'b0;
         tick_q <= 3'h0;
         bitIdx_q <= 6'h00;
         frame_q <= 32'h0;
         isWrite_q <= 1'b0;
      end else if (startReq) begin
         reqSeen_q <= reqSync2_q;
         isWrite_q <= reqWrite;
         frame_q <= {mgmt_frame_pkg::START_CODE, reqWrite ? mgmt_frame_pkg::OP_WRITE : mgmt_frame_pkg::OP_READ,
                     reqPhy, reqReg, mgmt_frame_pkg::TA_WRITE, reqData}; // RULE_14
         bitIdx_q <= reqPreamble ? mgmt_frame_pkg::PRE_FIRST : mgmt_frame_pkg::FRAME_FIRST; // RULE_14
         tick_q <= 3'h0;
         state_q <= ST_RUN;
      end else if (state_q == ST_RUN) begin
         tick_q <= tick_q + 3'h1;
         if (bitEnd) begin
            bitIdx_q <= bitIdx_q + 6'h01;
            if (inFrame) begin
               frame_q <= {frame_q[30:0], 1'b0};
            end
            if (bitIdx_q == mgmt_frame_pkg::LAST_BIT) begin
               state_q <= ST_IDLE;
            end
         end
      end
   end

   // Read capture. The sample point trails the rising edge enough to cover the pin synchroniser.
   always_ff @(posedge linkClk or negedge rst_n) begin
      if (!rst_n) begin
         ackSeen_q <= 1'b0;
         rdShift_q <= 16'h0;
      end else if (startReq) begin
         ackSeen_q <= 1'b0;
      end else if ((state_q == ST_RUN) && inFrame && (tick_q == mgmt_frame_pkg::TICK_SAMPLE)) begin
         if (fIdx == mgmt_frame_pkg::ACK_POS) begin
            ackSeen_q <= ~inSync2_q; // RULE_15
         end
         if (fIdx >= mgmt_frame_pkg::DATA_POS) begin
            rdShift_q <= {rdShift_q[14:0], inSync2_q};
         end
      end
   end

   // Answer: results and the toggle update in the same edge, held until the next frame ends.
   always_ff @(posedge linkClk or negedge rst_n) begin
      if (!rst_n) begin
         doneToggle <= 1'b0;
         rspData <= 16'h0;
         rspAck <= 1'b0;
      end else if (bitEnd && (bitIdx_q == mgmt_frame_pkg::LAST_BIT)) begin
         doneToggle <= ~doneToggle; // RULE_03
         rspData <= rdShift_q;
         rspAck <= ackSeen_q && !isWrite_q;
      end
   end

   // Pin drivers. The line is released at turnaround on reads so the device can answer.
   always_ff @(posedge linkClk or negedge rst_n) begin
      if (!rst_n) begin
         mgmtSerialClock <= 1'b0;
         mdioOut <= 1'b1;
         mdioOe <= 1'b0;
      end else begin
         mgmtSerialClock <= (state_q == ST_RUN) && (tick_q >= mgmt_frame_pkg::TICK_RISE);
         mdioOut <= inFrame ? frame_q[31] : 1'b1;
         mdioOe <= (state_q == ST_RUN) && (!inFrame || isWrite_q || (fIdx < mgmt_frame_pkg::TA_POS)); // RULE_15
      end
   end

   a_start_bit: assert property (@(posedge linkClk) disable iff (!rst_n)
      (state_q == ST_RUN) && (bitIdx_q == mgmt_frame_pkg::FRAME_FIRST) |=> !mdioOut && mdioOe) // RULE_14
      else $error("Start code does not open the frame.");
   a_ta_release: assert property (@(posedge linkClk) disable iff (!rst_n)
      (state_q == ST_RUN) && inFrame && !isWrite_q && (fIdx == mgmt_frame_pkg::TA_POS) |=> !mdioOe) // RULE_15
      else $error("Line still driven at read turnaround.");
   a_done_flip: assert property (@(posedge linkClk) disable iff (!rst_n)
      bitEnd && (bitIdx_q == mgmt_frame_pkg::LAST_BIT) |=> (doneToggle != $past(doneToggle)) && !state_q) // RULE_03
      else $error("Frame end did not report completion.");
endmodule : phy_mgmt_serial_engine

`default_nettype wire

/* File: phy_mgmt_user_access.sv */
// Purpose: User access engine of the management serial controller, two request channels.
// Assumes: Software writes a channel only while its launch flag is clear.
// Notes:   Frames run in the link clock domain; toggles carry requests and answers across.
//
// How it works
// [RULE_01] Software checks launch flag clear before access.
// [RULE_02] Write request: launch, write-select, addresses, data.
// [RULE_03] Device runs write itself, then clears launch.
// [RULE_04] Read request: launch and addresses, write-select clear.
// [RULE_05] Read result lands in channel data field.
// [RULE_06] Acknowledge flag set only on answered read.
// [RULE_07] Completion sets raw flag of issuing channel.
// [RULE_08] Enabled mask also sets masked flag, interrupt.
// [RULE_09] Software may skip waiting if checking idle.
// [RULE_10] Software rechecks presence flags from time to time.
// [RULE_11] Both channels pending are served round robin.
// [RULE_12] Channel reads update addressed PHY presence flag.
// [RULE_13] No transactions while module is disabled.
// [RULE_14] Standard frame: preamble, start, opcode, addresses, data.
// [RULE_15] Read releases line at turnaround; low means acknowledge.
`default_nettype none

module phy_mgmt_user_access (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic linkClk,
   input wire logic enable,
   input wire logic preambleEn,
   input wire logic [1:0] accessWrEn,
   input wire logic [1:0] accessGo,
   input wire logic [1:0] accessWriteSel,
   input wire logic [1:0][4:0] accessRegAddr,
   input wire logic [1:0][4:0] accessPhyAddr,
   input wire logic [1:0][15:0] accessData,
   input wire logic [1:0] cmdDoneMaskSet,
   input wire logic [1:0] cmdDoneMaskClear,
   input wire logic [1:0] cmdDoneRawClear,
   input wire logic mdioIn,
   output logic mgmtSerialClock,
   output logic mdioOut,
   output logic mdioOe,
   output logic [1:0] chGo,
   output logic [1:0] chWriteSel,
   output logic [1:0][4:0] chRegAddr,
   output logic [1:0][4:0] chPhyAddr,
   output logic [1:0][15:0] chData,
   output logic [1:0] chAck,
   output logic [1:0] cmdDoneRaw,
   output logic [1:0] cmdDoneMask,
   output logic [1:0] cmdDoneMasked,
   output logic cmdIntr,
   output logic [31:0] phyAlive
);
   // ****************************************
   // Declarations
   // ****************************************
   logic busy_q;               // A frame is outstanding in the link domain.
   logic curCh_q;              // Channel being served, also the last one served.
   logic reqToggle_q;          // Flips once per launched request.
   logic curWrite_q;           // Latched request fields, stable while busy.
   logic curPre_q;
   logic [4:0] curPhy_q;
   logic [4:0] curReg_q;
   logic [15:0] curData_q;
   logic doneSync1_q;          // First stage of the answer synchroniser.
   logic doneSync2_q;          // Second stage.
   logic doneSync3_q;          // Previous value of stage two for edge detection.
   logic doneToggle;           // Answer toggle from the link domain.
   logic [15:0] rspData;       // Read data, stable once the toggle is seen.
   logic rspAck;               // Acknowledge seen on the last frame; always low after a write.
   logic doneEvt;              // One-cycle completion pulse in this domain.
   logic launch;               // A request leaves for the link domain this cycle.
   logic pick;                 // Channel chosen by the arbiter.
   logic [1:0] rawSet;
   logic [1:0] raw_d;
   logic [1:0] mask_d;

   // ****************************************
   // Channel registers
   // ****************************************
   // A write to a busy channel is dropped so the fields under transfer never move.
   for (genvar c = 0; c < mgmt_frame_pkg::NUM_CH; c++) begin : g_ch
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            chGo[c] <= 1'b0;
            chWriteSel[c] <= 1'b0;
            chRegAddr[c] <= 5'h0;
            chPhyAddr[c] <= 5'h0;
            chData[c] <= 16'h0;
            chAck[c] <= 1'b0;
         end else if (doneEvt && (curCh_q == 1'(c))) begin
            chGo[c] <= 1'b0; // RULE_03
            if (!curWrite_q) begin
               chData[c] <= rspData; // RULE_05
               chAck[c] <= rspAck; // RULE_06
            end
         end else if (accessWrEn[c] && !chGo[c]) begin
            chGo[c] <= accessGo[c]; // RULE_02 RULE_04
            chWriteSel[c] <= accessWriteSel[c];
            chRegAddr[c] <= accessRegAddr[c];
            chPhyAddr[c] <= accessPhyAddr[c];
            chData[c] <= accessData[c];
            chAck[c] <= 1'b0;
         end
      end
   end

   // ****************************************
   // Arbiter and launch
   // ****************************************
   // When both channels wait, the one not served last goes next.
   assign pick = (&chGo) ? ~curCh_q : chGo[1]; // RULE_11
   assign launch = enable && !busy_q && (|chGo); // RULE_13

   // Launch copies the fields so the link domain sees a frozen request.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_q <= 1'b0;
         curCh_q <= 1'b0;
         reqToggle_q <= 1'b0;
         curWrite_q <= 1'b0;
         curPre_q <= 1'b1;
         curPhy_q <= 5'h0;
         curReg_q <= 5'h0;
         curData_q <= 16'h0;
      end else if (launch) begin
         busy_q <= 1'b1;
         curCh_q <= pick; // RULE_11
         reqToggle_q <= ~reqToggle_q;
         curWrite_q <= chWriteSel[pick]; // RULE_02 RULE_04
         curPre_q <= preambleEn;
         curPhy_q <= chPhyAddr[pick];
         curReg_q <= chRegAddr[pick];
         curData_q <= chData[pick];
      end else if (doneEvt) begin
         busy_q <= 1'b0;
      end
   end

   // ****************************************
   // Answer crossing
   // ****************************************
   // A toggle rather than a pulse, because the link clock may be slower than ours.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         doneSync1_q <= 1'b0;
         doneSync2_q <= 1'b0;
         doneSync3_q <= 1'b0;
      end else begin
         doneSync1_q <= doneToggle;
         doneSync2_q <= doneSync1_q;
         doneSync3_q <= doneSync2_q;
      end
   end

   assign doneEvt = doneSync2_q ^ doneSync3_q;

   // ****************************************
   // Completion flags
   // ****************************************
   // A completion in the same cycle as a clear keeps the flag set; mask clear beats mask set.
   assign rawSet = {doneEvt && curCh_q, doneEvt && !curCh_q}; // RULE_07
   assign raw_d = (cmdDoneRaw & ~cmdDoneRawClear) | rawSet;
   assign mask_d = (cmdDoneMask | cmdDoneMaskSet) & ~cmdDoneMaskClear;

   // Masked flags and the interrupt use next values so they line up with the raw flags.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cmdDoneRaw <= 2'h0;
         cmdDoneMask <= mgmt_frame_pkg::MASK_RST;
         cmdDoneMasked <= 2'h0;
         cmdIntr <= 1'b0;
      end else begin
         cmdDoneRaw <= raw_d; // RULE_07
         cmdDoneMask <= mask_d;
         cmdDoneMasked <= raw_d & mask_d; // RULE_08
         cmdIntr <= |(raw_d & mask_d); // RULE_08
      end
   end

   // Presence flags follow every channel read of the addressed PHY.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         phyAlive <= mgmt_frame_pkg::ALIVE_RST;
      end else if (doneEvt && !curWrite_q) begin
         phyAlive[curPhy_q] <= rspAck; // RULE_12
      end
   end

   // ****************************************
   // Link domain engine
   // ****************************************
   phy_mgmt_serial_engine i_phy_mgmt_serial_engine (
      .linkClk(linkClk),
      .rst_n(rst_n),
      .reqToggle(reqToggle_q),
      .reqWrite(curWrite_q),
      .reqPreamble(curPre_q),
      .reqPhy(curPhy_q),
      .reqReg(curReg_q),
      .reqData(curData_q),
      .mdioIn(mdioIn),
      .doneToggle(doneToggle),
      .rspData(rspData),
      .rspAck(rspAck),
      .mgmtSerialClock(mgmtSerialClock),
      .mdioOut(mdioOut),
      .mdioOe(mdioOe)
   );

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   a_go_clears: assert property (doneEvt |=> !chGo[$past(curCh_q)] && !busy_q) // RULE_03
      else $error("Launch flag not cleared on completion.");
   a_read_data: assert property (doneEvt && !curWrite_q |=> chData[$past(curCh_q)] == $past(rspData)) // RULE_05
      else $error("Read data not returned to channel.");
   a_ack_read: assert property (doneEvt && !curWrite_q |=> chAck[$past(curCh_q)] == $past(rspAck)) // RULE_06
      else $error("Acknowledge flag wrong after read.");
   a_raw_sets: assert property (doneEvt |=> cmdDoneRaw[$past(curCh_q)]) // RULE_07
      else $error("Raw completion flag not set.");
   a_masked_intr: assert property (cmdDoneMasked == (cmdDoneRaw & cmdDoneMask) && cmdIntr == |cmdDoneMasked) // RULE_08
      else $error("Masked flag or interrupt inconsistent.");
   a_round_robin: assert property (launch && (&chGo) |=> curCh_q != $past(curCh_q)) // RULE_11
      else $error("Round robin did not alternate.");
   a_alive_update: assert property (doneEvt && !curWrite_q |=> phyAlive[$past(curPhy_q)] == $past(rspAck)) // RULE_12
      else $error("Presence flag not updated by read.");
   a_idle_disabled: assert property (!enable && !busy_q |=> !busy_q && $stable(reqToggle_q)) // RULE_13
      else $error("Transaction launched while disabled.");
   a_launch_field: assert property (launch |=> busy_q && curWrite_q == $past(chWriteSel[pick])) // RULE_02
      else $error("Launch did not capture the request.");
endmodule : phy_mgmt_user_access

`default_nettype wire

/* File: phy_mgmt_user_access_tb.sv */
// Purpose: Self-checking bench for the two-channel user access engine.
// Assumes: One frame is at most 64 bits of eight link clock cycles.
// Notes:   Every scenario is its own task and judges its own results.
`default_nettype none

module phy_mgmt_user_access_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic linkClk = 1'b0;
   logic rst_n = 1'b0;
   logic enable = 1'b0;
   logic preambleEn = 1'b1;
   logic [1:0] accessWrEn = 2'h0;
   logic [1:0] accessGo = 2'h0;
   logic [1:0] accessWriteSel = 2'h0;
   logic [1:0][4:0] accessRegAddr = '0;
   logic [1:0][4:0] accessPhyAddr = '0;
   logic [1:0][15:0] accessData = '0;
   logic [1:0] cmdDoneMaskSet = 2'h0;
   logic [1:0] cmdDoneMaskClear = 2'h0;
   logic [1:0] cmdDoneRawClear = 2'h0;
   logic ackEn = 1'b1;
   logic [15:0] rdVal = 16'ha5c3;
   logic mdioIn, mgmtSerialClock, mdioOut, mdioOe, cmdIntr, gotWrite;
   logic [1:0] chGo, chWriteSel, chAck, cmdDoneRaw, cmdDoneMask, cmdDoneMasked;
   logic [1:0][4:0] chRegAddr, chPhyAddr;
   logic [1:0][15:0] chData;
   logic [31:0] phyAlive;
   logic [9:0] gotAddr;
   logic [15:0] gotData;
   int frames;
   int failCount = 0;
   int checksDone = 0;

   phy_mgmt_user_access i_phy_mgmt_user_access (.clk(clk), .rst_n(rst_n), .linkClk(linkClk), .enable(enable),
      .preambleEn(preambleEn), .accessWrEn(accessWrEn), .accessGo(accessGo), .accessWriteSel(accessWriteSel),
      .accessRegAddr(accessRegAddr), .accessPhyAddr(accessPhyAddr), .accessData(accessData),
      .cmdDoneMaskSet(cmdDoneMaskSet), .cmdDoneMaskClear(cmdDoneMaskClear), .cmdDoneRawClear(cmdDoneRawClear),
      .mdioIn(mdioIn), .mgmtSerialClock(mgmtSerialClock), .mdioOut(mdioOut), .mdioOe(mdioOe), .chGo(chGo),
      .chWriteSel(chWriteSel), .chRegAddr(chRegAddr), .chPhyAddr(chPhyAddr), .chData(chData), .chAck(chAck),
      .cmdDoneRaw(cmdDoneRaw), .cmdDoneMask(cmdDoneMask), .cmdDoneMasked(cmdDoneMasked), .cmdIntr(cmdIntr),
      .phyAlive(phyAlive));

   mgmt_phy_model i_mgmt_phy_model (.mgmtSerialClock(mgmtSerialClock), .mdioOut(mdioOut), .mdioOe(mdioOe),
      .ackEn(ackEn), .rdVal(rdVal), .mdioIn(mdioIn), .gotWrite(gotWrite), .gotAddr(gotAddr),
      .gotData(gotData), .frames(frames));

   // The link clock gets an odd offset; its rising edges still meet those of the system clock every 240 ns.
   initial begin
      forever #5 clk = ~clk;
   end
   initial begin
      #3;
      forever #24 linkClk = ~linkClk;
   end

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checksDone++;
      if (seen !== exp) begin
         failCount++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wrapUp;
      if (failCount == 0 && checksDone > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : wrapUp

   // One software write of a channel; returns once the channel shows it.
   task automatic access(input int c, input logic wr, input logic [4:0] phy, input logic [4:0] rg,
                         input logic [15:0] d);
      @(posedge clk);
      accessWrEn[c] <= 1'b1;
      accessGo[c] <= 1'b1;
      accessWriteSel[c] <= wr;
      accessPhyAddr[c] <= phy;
      accessRegAddr[c] <= rg;
      accessData[c] <= d;
      @(posedge clk);
      accessWrEn[c] <= 1'b0;
      @(posedge clk);
   endtask : access

   // Software waits for the launch flag to drop; the bound covers two queued frames.
   task automatic waitIdle(input int c);
      int n;
      n = 0;
      while (chGo[c] !== 1'b0 && n < 6000) begin
         @(posedge clk);
         n++;
      end
      check(32'(chGo[c]), 32'h0);
      @(posedge clk);
   endtask : waitIdle

   // Both channels queued at once while disabled; the first frame shows who won.
   task automatic tieRun(input logic firstWrite);
      int f;
      int n;
      enable <= 1'b0;
      access(0, 1'b0, 5'h03, 5'h02, 16'h0);
      access(1, 1'b1, 5'h1f, 5'h11, 16'h3c96);
      f = frames;
      n = 0;
      enable <= 1'b1;
      while (frames == f && n < 6000) begin
         @(posedge clk);
         n++;
      end
      check(32'(gotWrite), 32'(firstWrite));
      waitIdle(0);
      waitIdle(1);
      check(32'(gotData), 32'h3c96);
   endtask : tieRun

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic readWhileDisabled;
      check(32'(chGo[0]), 32'h0);
      access(0, 1'b0, 5'h03, 5'h02, 16'h0);
      repeat (300) @(posedge clk);
      check(32'({chGo[0], frames[0], mdioOe}), 32'h4);
      enable <= 1'b1;
      waitIdle(0);
      check(32'(chData[0]), 32'ha5c3);
      check(32'({chAck[0], cmdDoneRaw, cmdDoneMasked, cmdIntr}), 32'h28);
      check(32'({gotWrite, gotAddr}), 32'h062);
      check(phyAlive, 32'h8);
   endtask : readWhileDisabled

   // A masked write without preamble; a second write while busy must be dropped.
   task automatic maskedWrite;
      cmdDoneRawClear <= 2'h3;
      cmdDoneMaskSet <= 2'h2;
      preambleEn <= 1'b0;
      @(posedge clk);
      cmdDoneRawClear <= 2'h0;
      cmdDoneMaskSet <= 2'h0;
      access(1, 1'b1, 5'h1f, 5'h11, 16'h5a0f);
      access(1, 1'b1, 5'h1f, 5'h05, 16'h1234);
      check(32'({cmdDoneMask, cmdDoneRaw, chWriteSel[1], chPhyAddr[1], chRegAddr[1]}), 32'h47f1);
      waitIdle(1);
      check(32'({gotData, gotWrite}), 32'hb41f);
      check(32'({cmdDoneRaw, cmdDoneMasked, cmdIntr, chAck[1]}), 32'h2a);
   endtask : maskedWrite

   // A PHY that stays silent must clear the acknowledge and presence flags.
   task automatic silentPhy;
      ackEn <= 1'b0;
      tieRun(1'b0);
      check(32'(chAck[0]), 32'h0);
      check(phyAlive, 32'h0);
      cmdDoneMaskClear <= 2'h2;
      cmdDoneRawClear <= 2'h3;
      @(posedge clk);
      cmdDoneMaskClear <= 2'h0;
      cmdDoneRawClear <= 2'h0;
      @(posedge clk);
      @(posedge clk);
      check(32'({cmdDoneMask, cmdDoneRaw, cmdDoneMasked, cmdIntr}), 32'h0);
   endtask : silentPhy

   // Main sequence: reset, then the scenarios in an order that sets the arbiter history.
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      check(32'({mdioOe, mdioOut, chGo, cmdIntr}), 32'h8);
      readWhileDisabled();
      tieRun(1'b1);
      maskedWrite();
      silentPhy();
      wrapUp();
   end

   // The whole run needs about 115 us; five times that means a hang.
   initial begin
      #600000;
      failCount++;
      wrapUp();
   end
endmodule : phy_mgmt_user_access_tb
`default_nettype wire
